// [pkg/bkrtc_pkg.sv]
package bkrtc_pkg;
  // Host port placement after reset
  localparam logic [15:0] DEF_BASE = 16'h0070;
  localparam logic [15:0] DATA_OFS = 16'h0001;

  // Location indices inside a bank
  localparam logic [6:0] IDX_SEC = 7'h00;
  localparam logic [6:0] IDX_MIN = 7'h02;
  localparam logic [6:0] IDX_HR = 7'h04;
  localparam logic [6:0] IDX_DOW = 7'h06;
  localparam logic [6:0] IDX_DATE = 7'h07;
  localparam logic [6:0] IDX_MON = 7'h08;
  localparam logic [6:0] IDX_YEAR = 7'h09;
  localparam logic [6:0] IDX_CRA = 7'h0A;
  localparam logic [6:0] IDX_CRB = 7'h0B;
  localparam logic [6:0] IDX_CRC = 7'h0C;
  localparam logic [6:0] IDX_CRD = 7'h0D;
  localparam logic [6:0] IDX_UPPER = 7'h40;
  localparam logic [6:0] IDX_URAM_PTR = 7'h50;
  localparam logic [6:0] IDX_URAM_WIN = 7'h53;

  // Field positions
  localparam int CRA_DV_HI = 6;
  localparam int CRA_DV_LO = 4;
  localparam int CRB_SET = 7;
  localparam int CRB_DM = 2;
  localparam int CRB_HR24 = 1;
  localparam int CRB_DSE = 0;
  localparam int CRC_PF = 6;
  localparam int CRC_UF = 4;
  localparam int PM_BIT = 7;

  // Reset and fixed read values
  localparam logic [2:0] DV_RST = 3'h2;
  localparam logic [3:0] RS_RST = 4'h0;
  localparam logic [7:0] CRB_RST = 8'h02;
  localparam logic [7:0] CRD_VALUE = 8'h80;
  localparam logic [7:0] LOCK_READ = 8'hFF;
  localparam logic [1:0] BANK_GP = 2'h0;
  localparam logic [1:0] BANK_CLOCK = 2'h1;
  localparam logic [1:0] BANK_POWER = 2'h2;

  // Divider chain: 32768 Hz divided by 2^15, first update half way round
  localparam int DIV_BITS = 15;
  localparam logic [14:0] UPD_AT = 15'h3FFF;

  // Calendar arithmetic
  localparam logic [7:0] TEN = 8'h0A;
  localparam logic [7:0] SEC_WRAP = 8'h3C;
  localparam logic [7:0] LAST_SM = 8'h3B;
  localparam logic [7:0] HR_WRAP = 8'h18;
  localparam logic [7:0] HALF_DAY = 8'h0C;
  localparam logic [7:0] MON_LAST = 8'h0C;
  localparam logic [7:0] YEAR_WRAP = 8'h64;
  localparam logic [7:0] DOW_LAST = 8'h07;
  localparam logic [7:0] SUNDAY = 8'h01;
  localparam logic [7:0] FEBRUARY = 8'h02;
  localparam logic [7:0] APRIL = 8'h04;
  localparam logic [7:0] JUNE = 8'h06;
  localparam logic [7:0] SEPTEMBER = 8'h09;
  localparam logic [7:0] OCTOBER = 8'h0A;
  localparam logic [7:0] NOVEMBER = 8'h0B;
  localparam logic [7:0] FIRST_SUN_LAST = 8'h07;
  localparam logic [7:0] LAST_SUN_FIRST = 8'h19;
  localparam logic [7:0] DST_HOUR = 8'h01;
  localparam logic [7:0] DST_JUMP = 8'h03;
  localparam logic [7:0] LEAP_MASK = 8'h03;
  localparam logic [7:0] D28 = 8'h1C;
  localparam logic [7:0] D29 = 8'h1D;
  localparam logic [7:0] D30 = 8'h1E;
  localparam logic [7:0] D31 = 8'h1F;

  typedef enum logic [1:0] {CHAIN_STOP, CHAIN_HOLD, CHAIN_RUN} bkrtc_chain_t;

  typedef struct packed {
    logic [7:0] year;
    logic [7:0] mon;
    logic [7:0] date;
    logic [7:0] dow;
    logic [7:0] hr;
    logic [7:0] min;
    logic [7:0] sec;
  } bkrtc_time_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } bkrtc_io_t;

  localparam bkrtc_time_t TIME_RST = '{year: 8'h00, mon: 8'h01, date: 8'h01, dow: 8'h01,
                                       hr: 8'h00, min: 8'h00, sec: 8'h00};
endpackage

// [rtl/bkrtc_calendar.sv]
`timescale 1ns/10ps
module bkrtc_calendar (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic step,
  input wire logic fmt_bin,
  input wire logic hr24,
  input wire logic daylight_saving_enable,
  input wire logic wr_en,
  input wire logic [6:0] wr_idx,
  input wire logic [7:0] wr_data,
  output bkrtc_pkg::bkrtc_time_t now
);
  logic [7:0] s, m, h, dw, d, mo, y, h12, dim;
  logic fall, fell_back;
  bkrtc_pkg::bkrtc_time_t next_tm;

  // Stored value to plain binary, whichever format is active
  function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bin);
    if (bin) return v;
    return {4'h0, v[7:4]} * bkrtc_pkg::TEN + {4'h0, v[3:0]};
  endfunction

  function automatic logic [7:0] enc(input logic [7:0] b, input logic bin);
    logic [7:0] t, o;
    t = b / bkrtc_pkg::TEN;
    o = b % bkrtc_pkg::TEN;
    if (bin) return b;
    return {t[3:0], o[3:0]};
  endfunction

  // Two-digit year: 00 counts as leap, right for 2000
  function automatic logic [7:0] days_in(input logic [7:0] mon, input logic [7:0] yr);
    if (mon == bkrtc_pkg::FEBRUARY) begin
      return ((yr & bkrtc_pkg::LEAP_MASK) == 8'h00) ? bkrtc_pkg::D29 : bkrtc_pkg::D28;
    end
    if (mon == bkrtc_pkg::APRIL || mon == bkrtc_pkg::JUNE || mon == bkrtc_pkg::SEPTEMBER ||
        mon == bkrtc_pkg::NOVEMBER) begin
      return bkrtc_pkg::D30;
    end
    return bkrtc_pkg::D31;
  endfunction

  // One-second advance, worked in binary 24-hour form
  always_comb begin
    s = to_bin(now.sec, fmt_bin);
    m = to_bin(now.min, fmt_bin);
    dw = to_bin(now.dow, fmt_bin);
    d = to_bin(now.date, fmt_bin);
    mo = to_bin(now.mon, fmt_bin);
    y = to_bin(now.year, fmt_bin);
    h12 = to_bin({1'b0, now.hr[6:0]}, fmt_bin);
    if (hr24) begin
      h = to_bin(now.hr, fmt_bin);
    end else begin
      h = ((h12 == bkrtc_pkg::HALF_DAY) ? 8'h00 : h12) +
          (now.hr[bkrtc_pkg::PM_BIT] ? bkrtc_pkg::HALF_DAY : 8'h00);
    end
    dim = days_in(mo, y);
    fall = 1'b0;
    next_tm = now;
    if (daylight_saving_enable && s == bkrtc_pkg::LAST_SM && m == bkrtc_pkg::LAST_SM && h == bkrtc_pkg::DST_HOUR &&
        dw == bkrtc_pkg::SUNDAY && mo == bkrtc_pkg::APRIL && d <= bkrtc_pkg::FIRST_SUN_LAST) begin
      h = bkrtc_pkg::DST_JUMP;
      m = 8'h00;
      s = 8'h00;
    end else if (daylight_saving_enable && s == bkrtc_pkg::LAST_SM && m == bkrtc_pkg::LAST_SM &&
                 h == bkrtc_pkg::DST_HOUR && dw == bkrtc_pkg::SUNDAY &&
                 mo == bkrtc_pkg::OCTOBER && d >= bkrtc_pkg::LAST_SUN_FIRST && !fell_back) begin
      m = 8'h00;
      s = 8'h00;
      fall = 1'b1;
    end else begin
      s = s + 8'h01;
      if (s == bkrtc_pkg::SEC_WRAP) begin
        s = 8'h00;
        m = m + 8'h01;
      end
      if (m == bkrtc_pkg::SEC_WRAP) begin
        m = 8'h00;
        h = h + 8'h01;
      end
      if (h == bkrtc_pkg::HR_WRAP) begin
        h = 8'h00;
        dw = (dw >= bkrtc_pkg::DOW_LAST) ? bkrtc_pkg::SUNDAY : dw + 8'h01;
        d = d + 8'h01;
      end
      if (d > dim) begin
        d = 8'h01;
        mo = mo + 8'h01;
      end
      if (mo > bkrtc_pkg::MON_LAST) begin
        mo = 8'h01;
        y = y + 8'h01;
      end
      if (y == bkrtc_pkg::YEAR_WRAP) begin
        y = 8'h00;
      end
    end
    next_tm.sec = enc(s, fmt_bin);
    next_tm.min = enc(m, fmt_bin);
    next_tm.dow = enc(dw, fmt_bin);
    next_tm.date = enc(d, fmt_bin);
    next_tm.mon = enc(mo, fmt_bin);
    next_tm.year = enc(y, fmt_bin);
    h12 = (h >= bkrtc_pkg::HALF_DAY) ? h - bkrtc_pkg::HALF_DAY : h;
    if (h12 == 8'h00) begin
      h12 = bkrtc_pkg::HALF_DAY;
    end
    if (hr24) begin
      next_tm.hr = enc(h, fmt_bin);
    end else begin
      h12 = enc(h12, fmt_bin);
      next_tm.hr = {h >= bkrtc_pkg::HALF_DAY, h12[6:0]};
    end
  end

  // Host writes win over a same-cycle tick; the tick is simply skipped
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      now <= bkrtc_pkg::TIME_RST;
    end else if (wr_en) begin
      case (wr_idx)
        bkrtc_pkg::IDX_SEC: now.sec <= wr_data;
        bkrtc_pkg::IDX_MIN: now.min <= wr_data;
        bkrtc_pkg::IDX_HR: now.hr <= wr_data;
        bkrtc_pkg::IDX_DOW: now.dow <= wr_data;
        bkrtc_pkg::IDX_DATE: now.date <= wr_data;
        bkrtc_pkg::IDX_MON: now.mon <= wr_data;
        bkrtc_pkg::IDX_YEAR: now.year <= wr_data;
        default: ;
      endcase
    end else if (step) begin
      now <= next_tm;
    end
  end

  // Remembers the autumn step so the repeated hour is not stepped back again
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fell_back <= 1'b0;
    end else if (step && fall) begin
      fell_back <= 1'b1;
    end else if (step && h != bkrtc_pkg::DST_HOUR) begin
      fell_back <= 1'b0;
    end
  end
endmodule

// [rtl/bkrtc_top.sv]
`timescale 1ns/10ps
module bkrtc_top (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic osc_tick,
  input bkrtc_pkg::bkrtc_io_t io,
  input wire logic base_load,
  input wire logic [15:0] base_value,
  input wire logic access_lock,
  output logic io_hit,
  output logic [7:0] io_rdata,
  output logic io_rvalid
);
  localparam int BANK_LOCS = 64;
  localparam int URAM_LOCS = 128;
  localparam int BANKS = 3;

  // The update point is a fixed-width constant, so the chain must match it
  if (bkrtc_pkg::DIV_BITS != $bits(bkrtc_pkg::UPD_AT)) begin
    $error("divider chain width does not match update point");
  end

  logic [15:0] base;
  logic [7:0] index;
  logic [3:0] rate_sel;
  logic [2:0] divider_control_field;
  logic [7:0] rtc_control_b;
  logic pf, uf;
  logic [7:0] upper_ram_pointer;
  logic [bkrtc_pkg::DIV_BITS-1:0] div;
  logic [7:0] lower_ram [BANK_LOCS];
  logic [7:0] upper_ram [BANKS][BANK_LOCS];
  logic [7:0] uram [URAM_LOCS];
  logic [1:0] bank;
  bkrtc_pkg::bkrtc_chain_t mode;
  logic hit_idx, hit_dat, dat_wr, dat_rd, run_tick, step, per_ev, time_wr;
  logic [6:0] loc;
  logic [7:0] next_rdata;
  bkrtc_pkg::bkrtc_time_t now;

  // Bank choice: 010 general, 011 clock, 1xx power
  function automatic logic [1:0] bank_of(input logic [2:0] dv);
    if (dv[2]) return bkrtc_pkg::BANK_POWER;
    if (dv[0]) return bkrtc_pkg::BANK_CLOCK;
    return bkrtc_pkg::BANK_GP;
  endfunction

  // 000/001 freeze the oscillator, 11x hold the chain at zero
  function automatic bkrtc_pkg::bkrtc_chain_t chain_of(input logic [2:0] dv);
    bkrtc_pkg::bkrtc_chain_t c;
    case (dv)
      3'h0, 3'h1: c = bkrtc_pkg::CHAIN_STOP;
      3'h6, 3'h7: c = bkrtc_pkg::CHAIN_HOLD;
      default: c = bkrtc_pkg::CHAIN_RUN;
    endcase
    return c;
  endfunction

  // True when the next count raises tap rs-1, i.e. half a tap period in
  function automatic logic tap_rise(input logic [14:0] cnt, input logic [3:0] rs);
    logic [14:0] k_bit, low;
    k_bit = 15'h0001 << (rs - 4'h1);
    low = k_bit - 15'h0001;
    if (rs == 4'h0) return 1'b0;
    return ((cnt & low) == low) && ((cnt & k_bit) == 15'h0000);
  endfunction

  function automatic logic is_time(input logic [6:0] a);
    return a == bkrtc_pkg::IDX_SEC || a == bkrtc_pkg::IDX_MIN || a == bkrtc_pkg::IDX_HR ||
           a == bkrtc_pkg::IDX_DOW || a == bkrtc_pkg::IDX_DATE || a == bkrtc_pkg::IDX_MON ||
           a == bkrtc_pkg::IDX_YEAR;
  endfunction

  function automatic logic [7:0] time_field(input bkrtc_pkg::bkrtc_time_t t,
                                            input logic [6:0] a);
    logic [7:0] v;
    if (a == bkrtc_pkg::IDX_SEC) v = t.sec;
    else if (a == bkrtc_pkg::IDX_MIN) v = t.min;
    else if (a == bkrtc_pkg::IDX_HR) v = t.hr;
    else if (a == bkrtc_pkg::IDX_DOW) v = t.dow;
    else if (a == bkrtc_pkg::IDX_DATE) v = t.date;
    else if (a == bkrtc_pkg::IDX_MON) v = t.mon;
    else v = t.year;
    return v;
  endfunction

  // Port decode: index at base, data at base plus one
  assign hit_idx = io.addr == base;
  assign hit_dat = io.addr == base + bkrtc_pkg::DATA_OFS;
  assign io_hit = (hit_idx || hit_dat) && (io.rd || io.wr);
  assign dat_wr = hit_dat && io.wr && !access_lock;
  assign dat_rd = hit_dat && io.rd && !access_lock;
  assign loc = index[6:0];
  assign bank = bank_of(divider_control_field);
  assign mode = chain_of(divider_control_field);
  assign run_tick = osc_tick && mode == bkrtc_pkg::CHAIN_RUN;
  assign step = run_tick && div == bkrtc_pkg::UPD_AT;
  assign per_ev = run_tick && tap_rise(div, rate_sel);
  assign time_wr = dat_wr && is_time(loc);

  // Base is loaded by configuration, defaults back to 70h on reset
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      base <= bkrtc_pkg::DEF_BASE;
    end else if (base_load) begin
      base <= base_value;
    end
  end

  // Index stays writable while locked; only the data path is blocked
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      index <= 8'h00;
    end else if (hit_idx && io.wr) begin
      index <= io.wdata;
    end
  end

  // Control A and B; the update flag bit of A is not storage
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      divider_control_field <= bkrtc_pkg::DV_RST;
      rate_sel <= bkrtc_pkg::RS_RST;
      rtc_control_b <= bkrtc_pkg::CRB_RST;
    end else if (dat_wr && loc == bkrtc_pkg::IDX_CRA) begin
      divider_control_field <= io.wdata[bkrtc_pkg::CRA_DV_HI:bkrtc_pkg::CRA_DV_LO];
      rate_sel <= io.wdata[bkrtc_pkg::CRA_DV_LO-1:0];
    end else if (dat_wr && loc == bkrtc_pkg::IDX_CRB) begin
      rtc_control_b <= io.wdata;
    end
  end

  // Divider chain; wraps every 2^15 ticks, one second at 32768 Hz
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      div <= '0;
    end else if (mode == bkrtc_pkg::CHAIN_HOLD) begin
      div <= '0;
    end else if (run_tick) begin
      div <= div + 15'h0001;
    end
  end

  // Sticky flags; an event in the clearing read cycle survives
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pf <= 1'b0;
      uf <= 1'b0;
    end else begin
      if (per_ev) begin
        pf <= 1'b1;
      end else if (dat_rd && loc == bkrtc_pkg::IDX_CRC) begin
        pf <= 1'b0;
      end
      if (step && !rtc_control_b[bkrtc_pkg::CRB_SET]) begin
        uf <= 1'b1;
      end else if (dat_rd && loc == bkrtc_pkg::IDX_CRC) begin
        uf <= 1'b0;
      end
    end
  end

  // Time registers live in the calendar; SET freezes updates
  bkrtc_calendar u_cal (
    .mclk(mclk),
    .rstn(rstn),
    .step(step && !rtc_control_b[bkrtc_pkg::CRB_SET]),
    .fmt_bin(rtc_control_b[bkrtc_pkg::CRB_DM]),
    .hr24(rtc_control_b[bkrtc_pkg::CRB_HR24]),
    .daylight_saving_enable(rtc_control_b[bkrtc_pkg::CRB_DSE]),
    .wr_en(time_wr),
    .wr_idx(loc),
    .wr_data(io.wdata),
    .now(now)
  );

  // Shared lower storage; alarms and spare bytes sit here for all banks
  always_ff @(posedge mclk) begin
    if (dat_wr && loc < bkrtc_pkg::IDX_UPPER && !is_time(loc) &&
        loc != bkrtc_pkg::IDX_CRA && loc != bkrtc_pkg::IDX_CRB &&
        loc != bkrtc_pkg::IDX_CRC && loc != bkrtc_pkg::IDX_CRD) begin
      lower_ram[loc[5:0]] <= io.wdata;
    end
  end

  // Upper storage per bank, except the clock bank's two upper RAM access locations
  always_ff @(posedge mclk) begin
    if (dat_wr && loc >= bkrtc_pkg::IDX_UPPER &&
        !(bank == bkrtc_pkg::BANK_CLOCK &&
          (loc == bkrtc_pkg::IDX_URAM_PTR || loc == bkrtc_pkg::IDX_URAM_WIN))) begin
      upper_ram[bank][loc[5:0]] <= io.wdata;
    end
  end

  // Second-level pointer; bit 7 is kept but not used for decode
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      upper_ram_pointer <= 8'h00;
    end else if (dat_wr && bank == bkrtc_pkg::BANK_CLOCK && loc == bkrtc_pkg::IDX_URAM_PTR) begin
      upper_ram_pointer <= io.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (dat_wr && bank == bkrtc_pkg::BANK_CLOCK && loc == bkrtc_pkg::IDX_URAM_WIN) begin
      uram[upper_ram_pointer[6:0]] <= io.wdata;
    end
  end

  // Read selection; control registers ignore the bank
  always_comb begin
    next_rdata = 8'h00;
    if (hit_idx) begin
      next_rdata = index;
    end else if (access_lock) begin
      next_rdata = bkrtc_pkg::LOCK_READ;
    end else if (is_time(loc)) begin
      next_rdata = time_field(now, loc);
    end else if (loc == bkrtc_pkg::IDX_CRA) begin
      next_rdata = {1'b0, divider_control_field, rate_sel};
    end else if (loc == bkrtc_pkg::IDX_CRB) begin
      next_rdata = rtc_control_b;
    end else if (loc == bkrtc_pkg::IDX_CRC) begin
      next_rdata[bkrtc_pkg::CRC_PF] = pf;
      next_rdata[bkrtc_pkg::CRC_UF] = uf;
    end else if (loc == bkrtc_pkg::IDX_CRD) begin
      next_rdata = bkrtc_pkg::CRD_VALUE;
    end else if (loc < bkrtc_pkg::IDX_UPPER) begin
      next_rdata = lower_ram[loc[5:0]];
    end else if (bank == bkrtc_pkg::BANK_CLOCK && loc == bkrtc_pkg::IDX_URAM_PTR) begin
      next_rdata = upper_ram_pointer;
    end else if (bank == bkrtc_pkg::BANK_CLOCK && loc == bkrtc_pkg::IDX_URAM_WIN) begin
      next_rdata = uram[upper_ram_pointer[6:0]];
    end else begin
      next_rdata = upper_ram[bank][loc[5:0]];
    end
  end

  // Read data is registered, valid one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      io_rdata <= 8'h00;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= (hit_idx || hit_dat) && io.rd;
      if ((hit_idx || hit_dat) && io.rd) begin
        io_rdata <= next_rdata;
      end
    end
  end
endmodule

// [testbench/bkrtc_host.sv]
`timescale 1ns/10ps
module bkrtc_host (
  input wire logic mclk,
  input wire logic io_rvalid,
  input wire logic [7:0] io_rdata,
  output bkrtc_pkg::bkrtc_io_t io
);
  logic [15:0] base = bkrtc_pkg::DEF_BASE;

  initial io = '0;

  // One strobe cycle; address and data flip afterwards so stale values never match
  task automatic cycle(input logic [15:0] a, input logic r, input logic [7:0] d);
    @(posedge mclk);
    io <= '{addr: a, rd: r, wr: !r, wdata: d};
    @(posedge mclk);
    io <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
  endtask

  task automatic put(input logic [15:0] a, input logic [7:0] d);
    cycle(a, 1'b0, d);
  endtask

  // Bounded wait for the answer; a missing answer reads as unknown
  task automatic get(input logic [15:0] a, output logic [7:0] d);
    int n;
    cycle(a, 1'b1, 8'h00);
    #1;
    for (n = 0; n < 8 && io_rvalid !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    d = (io_rvalid === 1'b1) ? io_rdata : 8'hXX;
  endtask

  // Pointer first, then the data port
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    put(base, idx);
    put(base + 16'h0001, d);
  endtask

  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
    put(base, idx);
    get(base + 16'h0001, d);
  endtask

  // Only the masked field changes; other bits go back as read
  task automatic rmw(input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] val);
    logic [7:0] d;
    reg_rd(idx, d);
    reg_wr(idx, (d & ~mask) | (val & mask));
  endtask
endmodule

// [testbench/bkrtc_top_sva.sv]
`timescale 1ns/10ps
module bkrtc_checker (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic osc_tick,
  input bkrtc_pkg::bkrtc_io_t io,
  input wire logic base_load,
  input wire logic [15:0] base_value,
  input wire logic access_lock,
  input wire logic io_hit,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid
);
  logic [15:0] base_q;
  logic [7:0] idx_q;
  logic idx_sel;
  logic dat_sel;

  // Decode follows the relocatable base, so checks survive a move
  assign idx_sel = io.addr == base_q;
  assign dat_sel = io.addr == base_q + bkrtc_pkg::DATA_OFS;

  // Own copy of the port base
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      base_q <= bkrtc_pkg::DEF_BASE;
    end else if (base_load) begin
      base_q <= base_value;
    end
  end

  // Own copy of the index pointer
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      idx_q <= 8'h00;
    end else if (io.wr && idx_sel) begin
      idx_q <= io.wdata;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  hit_decode_a:
    assert property (io_hit == ((io.rd || io.wr) && (idx_sel || dat_sel)))
    else $error("port decode mismatch");
  read_answer_a:
    assert property (io.rd && io_hit |=> io_rvalid)
    else $error("read hit without answer");
  answer_cause_a:
    assert property (io_rvalid |-> $past(io.rd && io_hit))
    else $error("answer without read hit");
  data_hold_a:
    assert property ($past(rstn) && !io_rvalid |-> $stable(io_rdata))
    else $error("read data moved without answer");
  index_back_a:
    assert property (io.rd && idx_sel |=> io_rdata == $past(idx_q))
    else $error("index port readback wrong");
  lock_read_a:
    assert property (io.rd && dat_sel && access_lock |=> io_rdata == bkrtc_pkg::LOCK_READ)
    else $error("locked read not all ones");
  ctrl_d_a:
    assert property (io.rd && dat_sel && !access_lock && idx_q[6:0] == bkrtc_pkg::IDX_CRD
      |=> io_rdata == bkrtc_pkg::CRD_VALUE)
    else $error("control d value wrong");
  ctrl_a_top_a:
    assert property (io.rd && dat_sel && !access_lock && idx_q[6:0] == bkrtc_pkg::IDX_CRA
      |=> !io_rdata[7])
    else $error("control a top bit set");
endmodule

bind bkrtc_top bkrtc_checker u_chk (
  .mclk(mclk),
  .rstn(rstn),
  .osc_tick(osc_tick),
  .io(io),
  .base_load(base_load),
  .base_value(base_value),
  .access_lock(access_lock),
  .io_hit(io_hit),
  .io_rdata(io_rdata),
  .io_rvalid(io_rvalid)
);

// [testbench/tb.sv]
`timescale 1ns/10ps
module tb;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic osc_tick = 1'b0;
  logic base_load = 1'b0;
  logic [15:0] base_value = 16'h0000;
  logic access_lock = 1'b0;
  bkrtc_pkg::bkrtc_io_t io;
  logic io_hit;
  logic [7:0] io_rdata;
  logic io_rvalid;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;

  bkrtc_top u_dut (
    .mclk(mclk),
    .rstn(rstn),
    .osc_tick(osc_tick),
    .io(io),
    .base_load(base_load),
    .base_value(base_value),
    .access_lock(access_lock),
    .io_hit(io_hit),
    .io_rdata(io_rdata),
    .io_rvalid(io_rvalid)
  );

  bkrtc_host u_host (
    .mclk(mclk),
    .io_rvalid(io_rvalid),
    .io_rdata(io_rdata),
    .io(io)
  );

  always #12.5 mclk = ~mclk;

  // Timebase tick every other cycle keeps one second near 65536 cycles
  always @(posedge mclk) osc_tick <= ~osc_tick;

  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    u_host.reg_wr(idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
    logic [7:0] d;
    u_host.reg_rd(idx, d);
    chk(what, d, exp);
  endtask

  // Chain must be held while the clock is loaded
  task automatic set_time(input bkrtc_pkg::bkrtc_time_t t);
    wr({1'b0, bkrtc_pkg::IDX_SEC}, t.sec);
    wr({1'b0, bkrtc_pkg::IDX_MIN}, t.min);
    wr({1'b0, bkrtc_pkg::IDX_HR}, t.hr);
    wr({1'b0, bkrtc_pkg::IDX_DOW}, t.dow);
    wr({1'b0, bkrtc_pkg::IDX_DATE}, t.date);
    wr({1'b0, bkrtc_pkg::IDX_MON}, t.mon);
    wr({1'b0, bkrtc_pkg::IDX_YEAR}, t.year);
  endtask

  task automatic t_reset();
    logic [7:0] d;
    u_host.get(16'h0070, d);
    chk("index after reset", d, 8'h00);
    rd(8'h0A, 8'h20, "control a reset");
    rd(8'h0B, 8'h02, "control b reset");
    rd(8'h0D, 8'h80, "control d");
    u_host.put(16'h0070, 8'h8B);
    u_host.get(16'h0070, d);
    chk("index top bit", d, 8'h8B);
    u_host.get(16'h0071, d);
    chk("index top bit ignored", d, 8'h02);
  endtask

  task automatic t_banks();
    wr(8'h20, 8'h5A);
    wr(8'h50, 8'h11);
    wr(8'h0A, 8'h30);
    rd(8'h20, 8'h5A, "shared lower");
    rd(8'h0D, 8'h80, "control d bank1");
    wr(8'h50, 8'h7F);
    wr(8'h53, 8'hC3);
    wr(8'h50, 8'h00);
    wr(8'h53, 8'h3C);
    wr(8'h50, 8'h7F);
    rd(8'h53, 8'hC3, "upper ram top");
    rd(8'h50, 8'h7F, "upper ram pointer");
    wr(8'h0A, 8'h40);
    rd(8'h0B, 8'h02, "control b bank2");
    wr(8'h0A, 8'h20);
    rd(8'h50, 8'h11, "bank0 upper");
  endtask

  task automatic t_refused();
    logic [7:0] d;
    wr(8'h0D, 8'h00);
    rd(8'h0D, 8'h80, "control d written");
    wr(8'h0A, 8'hA0);
    rd(8'h0A, 8'h20, "control a top bit");
    @(posedge mclk);
    access_lock <= 1'b1;
    wr(8'h20, 8'h00);
    rd(8'h20, 8'hFF, "locked read");
    u_host.get(u_host.base, d);
    chk("locked index", d, 8'h20);
    @(posedge mclk);
    access_lock <= 1'b0;
    rd(8'h20, 8'h5A, "unlocked read");
  endtask

  task automatic t_base();
    logic [7:0] d;
    @(posedge mclk);
    base_value <= 16'h0170;
    base_load <= 1'b1;
    @(posedge mclk);
    base_load <= 1'b0;
    u_host.base = 16'h0170;
    rd(8'h20, 8'h5A, "relocated data");
    fork
      u_host.get(16'h0070, d);
      begin
        @(posedge mclk);
        #1;
        chk("old base hit", {7'h00, io_hit}, 8'h00);
      end
    join
  endtask

  // April change-over on the first update, with periodic flag timing on the way
  task automatic t_dst();
    logic [7:0] d;
    wr(8'h0A, 8'h63);
    u_host.rmw(8'h0B, 8'h07, 8'h03);
    set_time('{year: 8'h98, mon: 8'h04, date: 8'h01, dow: 8'h01,
               hr: 8'h01, min: 8'h59, sec: 8'h59});
    u_host.reg_rd(8'h0C, d);
    wr(8'h0A, 8'h23);
    u_host.reg_rd(8'h0C, d);
    chk("periodic early", d & 8'h40, 8'h00);
    repeat (16) @(posedge mclk);
    u_host.reg_rd(8'h0C, d);
    chk("periodic flag", d & 8'h40, 8'h40);
    repeat (32700) @(posedge mclk);
    rd(8'h00, 8'h59, "before first update");
    repeat (100) @(posedge mclk);
    rd(8'h00, 8'h00, "seconds after update");
    rd(8'h02, 8'h00, "minutes after update");
    rd(8'h04, 8'h03, "spring hour");
  endtask

  // Binary twelve-hour format, leap day reached at midnight from 11 PM
  task automatic t_leap();
    wr(8'h0A, 8'h63);
    u_host.rmw(8'h0B, 8'h07, 8'h04);
    set_time('{year: 8'h04, mon: 8'h02, date: 8'h1C, dow: 8'h03,
               hr: 8'h8B, min: 8'h3B, sec: 8'h3B});
    wr(8'h0A, 8'h23);
    repeat (32800) @(posedge mclk);
    rd(8'h07, 8'h1D, "leap date");
    rd(8'h08, 8'h02, "leap month");
    rd(8'h04, 8'h0C, "binary hour wrap");
    rd(8'h06, 8'h04, "binary day of week");
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_banks();
    t_refused();
    t_base();
    t_dst();
    t_leap();
    end_of_test();
  end
endmodule
